/* design/ovd_regs.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ovd_defines.svh"
// Summary of operation
// RL1 - 5-bit vertical offset: 0 up 16, 16 no shift, 31 down 15 pixels.
// RL2 - vertical offset written at 03h, read at 83h, upper bits ignored, resets 10h.
// RL3 - mode register written at 04h, read at 84h, bit 7 ignored, resets zero.
// RL4 - host writes mode register only while its clear bit reads zero.
// RL5 - 16-bit mode: character writes take attribute from mode bits 5 to 3.
// RL6 - 16-bit mode: display memory reads return character and attribute bytes.
// RL7 - 8-bit mode: byte-select zero writes character byte, one writes attribute.
// RL8 - background bit clear in external sync shows incoming video behind character; code shows background gray instead while bg_mode is set.
// RL9 - background bit set paints character background at chosen gray level.
// RL10 - internal sync treats background bit as set.
// RL11 - blink bit set blinks character with first video mode blink settings.
// RL12 - hidden blink phase in external sync shows incoming video.
// RL13 - hidden blink phase in internal sync shows background gray.
// RL14 - invert bit swaps white and black glyph pixels.
// RL15 - gray in eight 7 percent steps, 0 to 49 percent of white.
// RL16 - clear bit drops by itself after the 20 us memory fill.
// RL17 - mode register writes during a memory clear are ignored.
module ovd_regs
  import ovd_pkg::*;
#(
  parameter int CLEAR_CYCLES = `OVD_CLEAR_CYCLES
)
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic spi_cs_b,
  input wire logic spi_sclk,
  input wire logic spi_sdin,
  output logic spi_sdout_reg,
  input wire logic vsync_stb,
  input wire logic dm_wr_stb,
  input wire logic [7:0] dm_wr_data,
  input wire logic byte_sel,
  input wire logic glyph_on,
  input wire logic glyph_white,
  input wire ovd_attr_t glyph_attr,
  input wire logic internal_sync,
  input wire logic bg_mode,
  input wire logic [2:0] bg_brightness,
  input wire logic blink_visible,
  output logic signed [4:0] vert_shift_reg,
  output logic char_we_reg,
  output logic attr_we_reg,
  output logic [7:0] char_data_reg,
  output logic [7:0] attr_data_reg,
  output logic read_both_reg,
  output logic auto_inc_reg,
  output logic mem_clear_busy_reg,
  output ovd_pix_t pix_reg
);
  // parameter check at elaboration, counter is 16 bits wide
  if (CLEAR_CYCLES < 1 || CLEAR_CYCLES > 65535)
  begin : g_clear_cycles_check
    $error("CLEAR_CYCLES out of range");
  end

  logic sclk_q;
  logic [2:0] bit_cnt_reg;
  logic [7:0] rx_shift_reg;
  logic [7:0] tx_shift_reg;
  logic [7:0] addr_reg;
  logic data_phase_reg;
  logic [7:0] rx_byte;
  logic sclk_rise;
  logic sclk_fall;
  logic wr_stb;
  logic [4:0] vert_offset_reg;
  logic [6:0] mem_mode_reg;
  ovd_clr_state_t clr_state_reg;
  logic [15:0] clr_cnt_reg;
  logic mode_wr_ok;

  // serial edges, pins taken as synchronous
  assign sclk_rise = spi_sclk & ~sclk_q;
  assign sclk_fall = ~spi_sclk & sclk_q;
  assign rx_byte = {rx_shift_reg[6:0], spi_sdin};
  assign wr_stb = sclk_rise && !spi_cs_b && data_phase_reg && bit_cnt_reg == 3'd7 && !addr_reg[`OVD_ADDR_RD_BIT];
  assign mode_wr_ok = wr_stb && addr_reg == `OVD_ADDR_MODE_WR && clr_state_reg == OVD_CLR_IDLE; // [RL4] [RL17]

  // serial receive: address byte then data byte
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      sclk_q <= 1'b0;
      bit_cnt_reg <= 3'd0;
      rx_shift_reg <= 8'h00;
      addr_reg <= 8'h00;
      data_phase_reg <= 1'b0;
    end
    else
    begin
      sclk_q <= spi_sclk;
      if (spi_cs_b)
      begin
        bit_cnt_reg <= 3'd0;
        data_phase_reg <= 1'b0;
      end
      else if (sclk_rise)
      begin
        rx_shift_reg <= rx_byte;
        bit_cnt_reg <= bit_cnt_reg + 3'd1;
        if (bit_cnt_reg == 3'd7)
        begin
          if (!data_phase_reg)
            addr_reg <= rx_byte;
          data_phase_reg <= ~data_phase_reg;
        end
      end
    end
  end

  // serial transmit: readback loaded after a read address, msb first on falling edges
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      tx_shift_reg <= 8'h00;
      spi_sdout_reg <= 1'b0;
    end
    else if (!spi_cs_b && sclk_rise && !data_phase_reg && bit_cnt_reg == 3'd7)
    begin
      if (rx_byte == `OVD_ADDR_OFFSET_RD)
        tx_shift_reg <= {3'b000, vert_offset_reg}; // [RL2]
      else if (rx_byte == `OVD_ADDR_MODE_RD)
        tx_shift_reg <= {1'b0, mem_mode_reg}; // [RL3]
      else
        tx_shift_reg <= 8'h00;
    end
    else if (!spi_cs_b && sclk_fall && data_phase_reg)
    begin
      spi_sdout_reg <= tx_shift_reg[7];
      tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
    end
  end

  // vertical offset register and shift output
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      vert_offset_reg <= `OVD_OFFSET_RESET; // [RL2]
      vert_shift_reg <= 5'sd0;
    end
    else
    begin
      if (wr_stb && addr_reg == `OVD_ADDR_OFFSET_WR)
        vert_offset_reg <= rx_byte[4:0]; // [RL2]
      vert_shift_reg <= signed'(vert_offset_reg ^ `OVD_OFFSET_MID); // [RL1]
    end
  end

  // mode register and display memory clear sequence
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      mem_mode_reg <= `OVD_MODE_RESET; // [RL3]
      clr_state_reg <= OVD_CLR_IDLE;
      clr_cnt_reg <= 16'h0000;
    end
    else
    begin
      if (mode_wr_ok)
      begin
        mem_mode_reg <= rx_byte[6:0]; // [RL3]
        if (rx_byte[`OVD_MODE_CLEAR_BIT])
        begin
          mem_mode_reg[`OVD_MODE_AUTOINC_BIT] <= 1'b0;
          clr_state_reg <= rx_byte[`OVD_MODE_VSCLR_BIT] ? OVD_CLR_WAIT_VS : OVD_CLR_RUN;
          clr_cnt_reg <= 16'h0000;
        end
      end
      else
      begin
        case (clr_state_reg)
          OVD_CLR_WAIT_VS:
            if (vsync_stb)
              clr_state_reg <= OVD_CLR_RUN;
          OVD_CLR_RUN:
            if (clr_cnt_reg == 16'(CLEAR_CYCLES - 1))
            begin
              clr_state_reg <= OVD_CLR_IDLE;
              mem_mode_reg[`OVD_MODE_CLEAR_BIT] <= 1'b0; // [RL16]
            end
            else
              clr_cnt_reg <= clr_cnt_reg + 16'h0001;
          default:
            clr_state_reg <= OVD_CLR_IDLE;
        endcase
      end
    end
  end

  // status outputs
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      read_both_reg <= 1'b1;
      auto_inc_reg <= 1'b0;
      mem_clear_busy_reg <= 1'b0;
    end
    else
    begin
      read_both_reg <= ~mem_mode_reg[`OVD_MODE_8BIT_BIT]; // [RL6]
      auto_inc_reg <= mem_mode_reg[`OVD_MODE_AUTOINC_BIT];
      mem_clear_busy_reg <= clr_state_reg == OVD_CLR_RUN;
    end
  end

  // display memory write steering
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      char_we_reg <= 1'b0;
      attr_we_reg <= 1'b0;
      char_data_reg <= 8'h00;
      attr_data_reg <= 8'h00;
    end
    else
    begin
      char_we_reg <= 1'b0;
      attr_we_reg <= 1'b0;
      if (dm_wr_stb && !mem_mode_reg[`OVD_MODE_8BIT_BIT])
      begin
        char_we_reg <= 1'b1;
        attr_we_reg <= 1'b1;
        char_data_reg <= dm_wr_data;
        attr_data_reg <= {mem_mode_reg[5:3], 5'b00000}; // [RL5]
      end
      else if (dm_wr_stb)
      begin
        char_we_reg <= ~byte_sel; // [RL7]
        attr_we_reg <= byte_sel; // [RL7]
        if (byte_sel)
          attr_data_reg <= dm_wr_data;
        else
          char_data_reg <= dm_wr_data;
      end
    end
  end

  // character pixel composition
  ovd_pixel_mix u_mix (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .glyph_on(glyph_on),
    .glyph_white(glyph_white),
    .attr(glyph_attr),
    .internal_sync(internal_sync),
    .bg_mode(bg_mode),
    .bg_brightness(bg_brightness),
    .blink_visible(blink_visible),
    .pix_reg(pix_reg)
  );

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  property p_shift_map;
    ##1 vert_shift_reg == $signed({1'b0, $past(vert_offset_reg)}) - 6'sd16;
  endproperty
  a_shift_map: assert property (p_shift_map) else $error("vertical shift wrong"); // [RL1]

  property p_offset_write;
    (wr_stb && addr_reg == 8'h03) |=> vert_offset_reg == $past(rx_byte[4:0]);
  endproperty
  a_offset_write: assert property (p_offset_write) else $error("offset write lost"); // [RL2]

  property p_mode_locked;
    (clr_state_reg != OVD_CLR_IDLE && wr_stb) |=> $stable(mem_mode_reg[6:3]) && $stable(mem_mode_reg[1:0]);
  endproperty
  a_mode_locked: assert property (p_mode_locked) else $error("mode written during clear"); // [RL17]

  property p_clear_end;
    (clr_state_reg == OVD_CLR_RUN && clr_cnt_reg == 16'(CLEAR_CYCLES - 1))
      |=> clr_state_reg == OVD_CLR_IDLE && !mem_mode_reg[2];
  endproperty
  a_clear_end: assert property (p_clear_end) else $error("clear bit not released"); // [RL16]

  property p_clear_bound;
    clr_state_reg == OVD_CLR_RUN |-> clr_cnt_reg < 16'(CLEAR_CYCLES);
  endproperty
  a_clear_bound: assert property (p_clear_bound) else $error("clear overran"); // [RL16]

  property p_attr_copy;
    (dm_wr_stb && !mem_mode_reg[6]) |=> char_we_reg && attr_we_reg && attr_data_reg[7:5] == $past(mem_mode_reg[5:3]);
  endproperty
  a_attr_copy: assert property (p_attr_copy) else $error("attribute not copied"); // [RL5]

  property p_byte_steer;
    (dm_wr_stb && mem_mode_reg[6]) |=> (attr_we_reg == $past(byte_sel)) && (char_we_reg != $past(byte_sel));
  endproperty
  a_byte_steer: assert property (p_byte_steer) else $error("byte select wrong"); // [RL7]

  c_clear_run: cover property (mode_wr_ok && rx_byte[2] ##[1:1000] clr_state_reg == OVD_CLR_IDLE);
  c_mode8_attr: cover property (dm_wr_stb && mem_mode_reg[6] && byte_sel);
  c_vos_read: cover property (sclk_rise && !data_phase_reg && bit_cnt_reg == 3'd7 && rx_byte == 8'h83);
endmodule : ovd_regs
`default_nettype wire

/* design/ovd_defines.svh */
`ifndef OVD_DEFINES_SVH
`define OVD_DEFINES_SVH
// serial addresses, bit 7 of the address byte marks a read
`define OVD_ADDR_OFFSET_WR 8'h03
`define OVD_ADDR_OFFSET_RD 8'h83
`define OVD_ADDR_MODE_WR 8'h04
`define OVD_ADDR_MODE_RD 8'h84
`define OVD_ADDR_RD_BIT 7
// reset values
`define OVD_OFFSET_RESET 5'h10
`define OVD_MODE_RESET 7'h00
// display memory mode fields
`define OVD_MODE_8BIT_BIT 6
`define OVD_MODE_BG_SEL_BIT 5
`define OVD_MODE_BLINK_BIT 4
`define OVD_MODE_INVERT_BIT 3
`define OVD_MODE_CLEAR_BIT 2
`define OVD_MODE_VSCLR_BIT 1
`define OVD_MODE_AUTOINC_BIT 0
// shift from code: flipping the top bit gives code minus 16
`define OVD_OFFSET_MID 5'h10
// overlay levels in percent of white, gray steps of 7
`define OVD_LEVEL_WHITE 7'h64
`define OVD_LEVEL_BLACK 7'h00
`define OVD_GRAY_STEP 7'h07
// clear of display memory
`define OVD_CLEAR_TIME_NS 20000
`define OVD_CLK_PERIOD_NS 100
`define OVD_CLEAR_CYCLES (`OVD_CLEAR_TIME_NS / `OVD_CLK_PERIOD_NS)
`endif

/* design/ovd_pkg.sv */
package ovd_pkg;
  // character attribute bits, as stored in the attribute byte
  typedef struct packed {
    logic bg_sel;
    logic blink;
    logic invert;
  } ovd_attr_t;

  // composed overlay pixel
  typedef struct packed {
    logic use_video;
    logic [6:0] level_pct;
  } ovd_pix_t;

  typedef enum logic [1:0] {
    OVD_CLR_IDLE = 2'b00,
    OVD_CLR_WAIT_VS = 2'b01,
    OVD_CLR_RUN = 2'b10
  } ovd_clr_state_t;
endpackage : ovd_pkg

/* design/ovd_pixel_mix.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ovd_defines.svh"
module ovd_pixel_mix
  import ovd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic glyph_on,
  input wire logic glyph_white,
  input wire ovd_attr_t attr,
  input wire logic internal_sync,
  input wire logic bg_mode,
  input wire logic [2:0] bg_brightness,
  input wire logic blink_visible,
  output ovd_pix_t pix_reg
);
  logic bg_gray;
  logic hidden;
  logic [6:0] gray_level;

  // background choice and gray level
  assign bg_gray = internal_sync | bg_mode | attr.bg_sel; // [RL9] [RL10]
  assign hidden = attr.blink & ~blink_visible; // [RL11]
  assign gray_level = 7'(bg_brightness) * `OVD_GRAY_STEP; // [RL15]

  // registered pixel composition
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      pix_reg <= '{use_video: 1'b1, level_pct: `OVD_LEVEL_BLACK};
    end
    else if (hidden)
    begin
      if (internal_sync)
        pix_reg <= '{use_video: 1'b0, level_pct: gray_level}; // [RL13]
      else
        pix_reg <= '{use_video: 1'b1, level_pct: `OVD_LEVEL_BLACK}; // [RL12]
    end
    else if (glyph_on)
    begin
      pix_reg.use_video <= 1'b0;
      pix_reg.level_pct <= (glyph_white ^ attr.invert) ? `OVD_LEVEL_WHITE : `OVD_LEVEL_BLACK; // [RL14]
    end
    else
    begin
      pix_reg.use_video <= ~bg_gray; // [RL8]
      pix_reg.level_pct <= bg_gray ? gray_level : `OVD_LEVEL_BLACK; // [RL9]
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  property p_int_no_video;
    internal_sync |=> !pix_reg.use_video;
  endproperty
  a_int_no_video: assert property (p_int_no_video) else $error("video shown in internal sync"); // [RL10]

  property p_gray_level;
    (!glyph_on && !(attr.blink && !blink_visible) && (internal_sync || bg_mode || attr.bg_sel))
      |=> pix_reg.level_pct == $past(bg_brightness) * 7;
  endproperty
  a_gray_level: assert property (p_gray_level) else $error("gray level wrong"); // [RL15]

  property p_invert;
    (glyph_on && !hidden) |=> pix_reg.level_pct == (($past(glyph_white) ^ $past(attr.invert)) ? 7'd100 : 7'd0);
  endproperty
  a_invert: assert property (p_invert) else $error("glyph polarity wrong"); // [RL14]

  property p_ext_bg_video;
    (!glyph_on && !hidden && !internal_sync && !bg_mode && !attr.bg_sel) |=> pix_reg.use_video;
  endproperty
  a_ext_bg_video: assert property (p_ext_bg_video) else $error("background not video"); // [RL8]

  property p_blink_hidden_ext;
    (hidden && !internal_sync) |=> pix_reg.use_video;
  endproperty
  a_blink_hidden_ext: assert property (p_blink_hidden_ext) else $error("hidden blink not video"); // [RL12]

  c_blink_hidden: cover property (hidden ##1 !hidden);
endmodule : ovd_pixel_mix
`default_nettype wire

/* dv/ovd_spi_host.sv */
`timescale 1ns/10ps
`default_nettype none
module ovd_spi_host
(
  input wire logic clk_sys,
  input wire logic spi_sdout_reg,
  output logic spi_cs_b,
  output logic spi_sclk,
  output logic spi_sdin
);
  // idle frame: deselected, clock parked low
  initial
  begin
    spi_cs_b = 1'b1;
    spi_sclk = 1'b0;
    spi_sdin = 1'b0;
  end

  // one frame: address byte then data byte, msb first, 4 clocks per phase
  task automatic xfer(input logic [7:0] adr, input logic [7:0] dat, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {adr, dat};
    rd = 8'h00;
    @(posedge clk_sys);
    spi_cs_b <= 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      spi_sdin <= sh[i];
      repeat (4) @(posedge clk_sys);
      spi_sclk <= 1'b1;
      // read bit settled since the last falling clock
      if (i < 8)
        rd[i] = spi_sdout_reg;
      repeat (4) @(posedge clk_sys);
      spi_sclk <= 1'b0;
    end
    repeat (4) @(posedge clk_sys);
    spi_cs_b <= 1'b1;
    spi_sdin <= ~spi_sdin; // released line shows no stale bit
  endtask : xfer
endmodule : ovd_spi_host
`default_nettype wire

/* dv/ovd_regs_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module ovd_regs_tb
  import ovd_pkg::*;
;
  logic clk_sys, rst_b, spi_cs_b, spi_sclk, spi_sdin, spi_sdout_reg, vsync_stb, dm_wr_stb, byte_sel;
  logic glyph_on, glyph_white, internal_sync, bg_mode, blink_visible;
  logic [7:0] dm_wr_data, char_data_reg, attr_data_reg, q;
  logic [2:0] bg_brightness;
  ovd_attr_t glyph_attr;
  logic signed [4:0] vert_shift_reg;
  logic char_we_reg, attr_we_reg, read_both_reg, auto_inc_reg, mem_clear_busy_reg;
  ovd_pix_t pix_reg;
  int bad_count, check_count, cyc;

  ovd_regs #(.CLEAR_CYCLES(400)) u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .spi_cs_b(spi_cs_b),
    .spi_sclk(spi_sclk), .spi_sdin(spi_sdin), .spi_sdout_reg(spi_sdout_reg), .vsync_stb(vsync_stb),
    .dm_wr_stb(dm_wr_stb), .dm_wr_data(dm_wr_data), .byte_sel(byte_sel), .glyph_on(glyph_on),
    .glyph_white(glyph_white), .glyph_attr(glyph_attr), .internal_sync(internal_sync), .bg_mode(bg_mode),
    .bg_brightness(bg_brightness), .blink_visible(blink_visible), .vert_shift_reg(vert_shift_reg),
    .char_we_reg(char_we_reg), .attr_we_reg(attr_we_reg), .char_data_reg(char_data_reg),
    .attr_data_reg(attr_data_reg), .read_both_reg(read_both_reg), .auto_inc_reg(auto_inc_reg),
    .mem_clear_busy_reg(mem_clear_busy_reg), .pix_reg(pix_reg));
  ovd_spi_host u_host (.clk_sys(clk_sys), .spi_sdout_reg(spi_sdout_reg), .spi_cs_b(spi_cs_b),
    .spi_sclk(spi_sclk), .spi_sdin(spi_sdin));

  // 100 ns clock
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic complete_run;
    if (bad_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.xfer(a, d, q);
  endtask : wr

  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] exp);
    u_host.xfer(a, 8'h00, q);
    check(nm, q, exp);
  endtask : rd

  // one memory byte strobe, then the registered write pulses
  task automatic mem(input logic [7:0] d, input logic sel, input logic ec, input logic ea, input logic [7:0] eatt);
    @(posedge clk_sys);
    dm_wr_stb <= 1'b1;
    dm_wr_data <= d;
    byte_sel <= sel;
    @(posedge clk_sys);
    dm_wr_stb <= 1'b0;
    @(negedge clk_sys);
    check("char_we", {7'h00, char_we_reg}, {7'h00, ec});
    check("attr_we", {7'h00, attr_we_reg}, {7'h00, ea});
    if (ec)
      check("char_data", char_data_reg, d);
    if (ea)
      check("attr_data", attr_data_reg, eatt);
  endtask : mem

  // pixel case; exp[7] set means incoming video expected
  task automatic px(input logic [5:0] cfg, input ovd_attr_t at, input logic [2:0] br, input logic [7:0] exp);
    @(posedge clk_sys);
    {internal_sync, bg_mode, glyph_on, glyph_white, blink_visible, byte_sel} <= cfg;
    glyph_attr <= at;
    bg_brightness <= br;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    if (exp[7])
      check("pix_video", {7'h00, pix_reg.use_video}, 8'h01);
    else
      check("pix", pix_reg, exp);
  endtask : px

  // hang guard
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      complete_run();
    end
  end

  initial
  begin
    bad_count = 0;
    check_count = 0;
    cyc = 0;
    rst_b = 1'b0;
    {vsync_stb, dm_wr_stb, byte_sel, glyph_on, glyph_white, internal_sync, bg_mode, blink_visible} = 8'h00;
    dm_wr_data = 8'h00;
    bg_brightness = 3'b000;
    glyph_attr = 3'b000;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(negedge clk_sys);
    check("shift_rst", {3'b000, vert_shift_reg}, 8'h00);
    rd("vos_rst", 8'h83, 8'h10);
    rd("dmm_rst", 8'h84, 8'h00);
    // offset codes at both ends and with ignored upper bits
    wr(8'h03, 8'h00);
    check("shift_up", {3'b000, vert_shift_reg}, 8'h10);
    wr(8'h03, 8'h1F);
    check("shift_down", {3'b000, vert_shift_reg}, 8'h0F);
    wr(8'h03, 8'hE5);
    check("shift_mid", {3'b000, vert_shift_reg}, 8'h15);
    rd("vos_rd", 8'h83, 8'h05);
    // 16-bit mode with all attributes and auto increment
    wr(8'h04, 8'hB9);
    rd("dmm_rd", 8'h84, 8'h39);
    check("modes", {6'h00, read_both_reg, auto_inc_reg}, 8'h03);
    mem(8'h41, 1'b1, 1'b1, 1'b1, 8'hE0);
    // 8-bit mode, byte select steers the byte
    wr(8'h04, 8'h40);
    check("read_both", {7'h00, read_both_reg}, 8'h00);
    mem(8'h5A, 1'b0, 1'b1, 1'b0, 8'h00);
    mem(8'hA5, 1'b1, 1'b0, 1'b1, 8'hA5);
    // memory clear, a write during it is dropped
    wr(8'h04, 8'h05);
    check("busy", {7'h00, mem_clear_busy_reg}, 8'h01);
    rd("dmm_busy", 8'h84, 8'h04);
    wr(8'h04, 8'h48);
    for (int i = 0; i < 1000 && mem_clear_busy_reg !== 1'b0; i++)
      @(negedge clk_sys);
    check("busy_end", {7'h00, mem_clear_busy_reg}, 8'h00);
    rd("dmm_done", 8'h84, 8'h00);
    // clear armed for vertical sync waits for the strobe
    wr(8'h04, 8'h06);
    check("vs_wait", {7'h00, mem_clear_busy_reg}, 8'h00);
    @(posedge clk_sys);
    vsync_stb <= 1'b1;
    @(posedge clk_sys);
    vsync_stb <= 1'b0;
    repeat (2) @(negedge clk_sys);
    check("vs_busy", {7'h00, mem_clear_busy_reg}, 8'h01);
    for (int i = 0; i < 1000 && mem_clear_busy_reg !== 1'b0; i++)
      @(negedge clk_sys);
    check("vs_busy_end", {7'h00, mem_clear_busy_reg}, 8'h00);
    rd("dmm_vs_done", 8'h84, 8'h02);
    // cfg = {internal, bg_mode, glyph_on, glyph_white, visible, byte_sel}
    px(6'b000010, 3'b000, 3'h5, 8'h80);
    px(6'b000010, 3'b100, 3'h5, 8'h23);
    px(6'b010010, 3'b000, 3'h0, 8'h00);
    px(6'b100010, 3'b000, 3'h7, 8'h31);
    px(6'b001110, 3'b000, 3'h2, 8'h64);
    px(6'b001110, 3'b001, 3'h2, 8'h00);
    px(6'b001100, 3'b010, 3'h2, 8'h80);
    px(6'b101100, 3'b010, 3'h3, 8'h15);
    px(6'b001110, 3'b010, 3'h3, 8'h64);
    complete_run();
  end
endmodule : ovd_regs_tb
`default_nettype wire
